// ===== src/lbst_params.svh
`ifndef LBST_PARAMS_SVH
`define LBST_PARAMS_SVH
// Contract
// - commands count only with clock enable high twice and exit time over
// - any command outside the state tables is flagged illegal
// - a bank is idle only after reset, precharge or auto precharge plus tRP, or refresh plus tRFCpb
// - a bank is active after activate plus tRCD with nothing in progress
// - read without auto precharge holds reading until burst ends or stops
// - write without auto precharge holds writing until burst ends or stops
// - precharge occupies the bank for tRP, then idle
// - activate occupies the bank for tRCD, then active
// - read or write with auto precharge occupies bank until tRP, then idle
// - per-bank refresh occupies that bank for tRFCpb, then idle
// - all-bank refresh occupies the device for tRFCab, then all idle
// - mode register read lasts tMRR; from idle all idle, else active kept
// - mode register write lasts tMRW, then all banks idle
// - precharge all lasts tRP, then every bank idle
// - precharge to an idle bank still imposes full tRP
// - burst terminate stops the latest burst, any bank, back to active
// - read or write to a bursting bank starts a new burst
// - a read to another bank starts reading there whatever bank n does
// - mode register read moves device to idle or active register reading
// - auto precharge bit closes the bank once the burst finishes
`define LBST_NUM_BANKS 8
`define LBST_BANK_W 3
// timer width bounds every cycle count below
`define LBST_TMR_W 8
`define LBST_RP_CYC 4
`define LBST_RCD_CYC 4
`define LBST_BURST_CYC 4
`define LBST_RFCPB_CYC 30
`define LBST_RFCAB_CYC 60
`define LBST_MRR_CYC 2
`define LBST_MRW_CYC 5
`define LBST_INIT_CYC 100
`define LBST_XP_CYC 3
`endif

// ===== src/lbst_pkg.sv
`default_nettype none
`include "lbst_params.svh"
package lbst_pkg;

  typedef enum logic [3:0] {
    OP_NOP, OP_ACT, OP_RD, OP_WR, OP_PRE, OP_PREA,
    OP_REFPB, OP_REFAB, OP_MRR, OP_MRW, OP_RESET, OP_BST
  } lbst_op_t;

  typedef enum logic [3:0] {
    BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READING, BK_WRITING,
    BK_RD_AP, BK_WR_AP, BK_PRECHARGING, BK_REFRESHING
  } lbst_bank_st_t;

  typedef enum logic [2:0] {
    DV_NORMAL, DV_REF_ALL, DV_MRR_IDLE, DV_MRR_ACT, DV_MRR_RST,
    DV_MRW, DV_PRE_ALL, DV_RESETTING
  } lbst_dev_st_t;

  typedef enum logic [2:0] {
    ERR_NONE, ERR_CKE, ERR_BUSY, ERR_BANK, ERR_STATE
  } lbst_err_t;

  typedef struct packed {
    logic                     valid;
    lbst_op_t                 op;
    logic [`LBST_BANK_W-1:0]  bank;
    logic                     ap;
  } lbst_cmd_t;

endpackage
`default_nettype wire

// ===== src/lbst_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "lbst_params.svh"
module lbst_bank
  import lbst_pkg::*;
#(
  parameter int TW    = `LBST_TMR_W,
  parameter int RP    = `LBST_RP_CYC,
  parameter int RCD   = `LBST_RCD_CYC,
  parameter int BURST = `LBST_BURST_CYC,
  parameter int RFCPB = `LBST_RFCPB_CYC
)
(
  input  wire logic          clk,
  input  wire logic          srst,
  input  wire logic          sel,
  input  wire lbst_op_t      op,
  input  wire logic          ap,
  input  wire logic          pre_all,
  input  wire logic          bst,
  output wire lbst_bank_st_t st_o,
  output wire logic          accept_o,
  output wire logic          pre_ok_o
);

  lbst_bank_st_t   st_reg;
  lbst_bank_st_t   st_next;
  logic [TW-1:0]   tmr_reg;
  logic [TW-1:0]   tmr_next;

  wire idle      = (st_reg == BK_IDLE);
  wire tmr_done  = (tmr_reg == '0);
  wire burst_src = st_reg inside {BK_ACTIVE, BK_READING, BK_WRITING};
  wire act_ok    = sel & (op == OP_ACT) & idle;
  wire rd_ok     = sel & (op == OP_RD) & burst_src;
  wire wr_ok     = sel & (op == OP_WR) & burst_src;
  wire ref_ok    = sel & (op == OP_REFPB) & idle;
  wire pre_one   = sel & (op == OP_PRE) & pre_ok_o;
  wire pre_go    = pre_one | pre_all;
  wire bst_ok    = bst & (st_reg inside {BK_READING, BK_WRITING});

  // precharge is valid on idle as well as on open rows
  assign pre_ok_o = st_reg inside {BK_IDLE, BK_ACTIVE,
                                   BK_READING, BK_WRITING};
  // transitional states accept nothing addressed to them
  assign accept_o = act_ok | rd_ok | wr_ok | ref_ok | pre_one;
  assign st_o     = st_reg;

  always_comb
  begin
    st_next  = st_reg;
    tmr_next = tmr_done ? tmr_reg : tmr_reg - 1'b1;
    if (pre_go)
    begin
      st_next  = BK_PRECHARGING;
      tmr_next = TW'(RP - 1);
    end
    else if (act_ok)
    begin
      st_next  = BK_ACTIVATING;
      tmr_next = TW'(RCD - 1);
    end
    else if (rd_ok | wr_ok)
    begin
      // new burst from active, reading or writing
      if (ap)
      begin
        st_next  = rd_ok ? BK_RD_AP : BK_WR_AP;
        tmr_next = TW'(BURST + RP - 1);
      end
      else
      begin
        st_next  = rd_ok ? BK_READING : BK_WRITING;
        tmr_next = TW'(BURST - 1);
      end
    end
    else if (ref_ok)
    begin
      st_next  = BK_REFRESHING;
      tmr_next = TW'(RFCPB - 1);
    end
    else if (bst_ok)
    begin
      st_next = BK_ACTIVE;
    end
    else if (tmr_done)
    begin
      case (st_reg)
        BK_ACTIVATING:  st_next = BK_ACTIVE;
        BK_READING:     st_next = BK_ACTIVE;
        BK_WRITING:     st_next = BK_ACTIVE;
        BK_RD_AP:       st_next = BK_IDLE;
        BK_WR_AP:       st_next = BK_IDLE;
        BK_PRECHARGING: st_next = BK_IDLE;
        BK_REFRESHING:  st_next = BK_IDLE;
        default:        st_next = st_reg;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_reg  <= BK_IDLE;
      tmr_reg <= '0;
    end
    else
    begin
      st_reg  <= st_next;
      tmr_reg <= tmr_next;
    end
  end

endmodule
`default_nettype wire

// ===== src/lbst_tracker.sv
`timescale 1ns/1ps
`default_nettype none
`include "lbst_params.svh"
module lbst_tracker
  import lbst_pkg::*;
#(
  parameter int NB    = `LBST_NUM_BANKS,
  parameter int BW    = `LBST_BANK_W,
  parameter int TW    = `LBST_TMR_W,
  parameter int RP    = `LBST_RP_CYC,
  parameter int RCD   = `LBST_RCD_CYC,
  parameter int BURST = `LBST_BURST_CYC,
  parameter int RFCPB = `LBST_RFCPB_CYC,
  parameter int RFCAB = `LBST_RFCAB_CYC,
  parameter int MRR   = `LBST_MRR_CYC,
  parameter int MRW   = `LBST_MRW_CYC,
  parameter int INIT  = `LBST_INIT_CYC,
  parameter int XP    = `LBST_XP_CYC
)
(
  input  wire logic                     clk,
  input  wire logic                     srst,
  input  wire logic                     cke,
  input  wire lbst_cmd_t                cmd,
  output wire lbst_bank_st_t [NB-1:0]   bank_state,
  output lbst_dev_st_t                  dev_state,
  output logic [BW-1:0]                 last_bank,
  output logic                          cmd_accept,
  output logic                          cmd_illegal,
  output lbst_err_t                     err_cause,
  output logic                          cmd_ready,
  output logic                          all_idle
);

  // clock enable history and exit wait
  logic            cke_prev_reg;
  logic [TW-1:0]   xit_reg;
  logic [TW-1:0]   xit_next;

  // device-wide state
  lbst_dev_st_t    dev_st_reg;
  lbst_dev_st_t    dev_st_next;
  logic [TW-1:0]   dtm_reg;
  logic [TW-1:0]   dtm_next;

  // most recent burst owner
  logic [BW-1:0]   last_bank_reg;
  logic            last_vld_reg;

  // registered results
  logic            accept_reg;
  logic            illegal_reg;
  lbst_err_t       err_reg;
  lbst_err_t       err_next;

  // per-bank vectors
  wire [NB-1:0]    bank_sel;
  wire [NB-1:0]    bank_bst;
  wire [NB-1:0]    bank_acc;
  wire [NB-1:0]    pre_ok_vec;
  wire [NB-1:0]    idle_vec;
  wire [NB-1:0]    mrr_blk_vec;

  // clock enable gating
  wire cke_rise = cke & ~cke_prev_reg;
  wire xit_done = (xit_reg == '0);
  wire cke_ok   = cke & cke_prev_reg & xit_done;

  // every rise restarts the exit wait, so even a one-cycle dip of the
  // enable costs the whole wait again
  assign xit_next = cke_rise ? TW'(XP)
                  : (xit_done ? xit_reg : xit_reg - 1'b1);

  // command decode
  wire is_cmd     = cmd.valid & (cmd.op != OP_NOP);
  wire dev_free   = (dev_st_reg == DV_NORMAL);
  wire dev_rst    = (dev_st_reg == DV_RESETTING);
  wire go         = is_cmd & cke_ok & dev_free;
  wire bank_op    = cmd.op inside {OP_ACT, OP_RD, OP_WR,
                                   OP_PRE, OP_REFPB};
  // only reachable when fewer banks are built than the field can name
  wire bank_range = (int'(cmd.bank) < NB);
  wire all_idle_w = &idle_vec;
  wire rw_op      = cmd.op inside {OP_RD, OP_WR};

  // burst terminate follows the last burst, not the bank field
  lbst_bank_st_t last_st;
  assign last_st = bank_state[last_bank_reg];

  // a burst that already ran out leaves nothing to stop, so refuse it
  wire bst_go = go & (cmd.op == OP_BST) & last_vld_reg
              & (last_st inside {BK_READING, BK_WRITING});

  // device-wide commands
  wire prea_go  = go & (cmd.op == OP_PREA) & (&pre_ok_vec);
  wire refab_go = go & (cmd.op == OP_REFAB) & all_idle_w;
  wire mrw_go   = go & (cmd.op == OP_MRW) & all_idle_w;
  wire rst_go   = go & (cmd.op == OP_RESET) & all_idle_w;
  wire mrr_go   = go & (cmd.op == OP_MRR) & ~(|mrr_blk_vec);
  wire mrr_rst  = is_cmd & cke_ok & dev_rst
                & (cmd.op == OP_MRR);

  wire dev_acc  = prea_go | refab_go | mrw_go | rst_go
                | mrr_go | mrr_rst;
  wire acc_w    = (|bank_acc) | bst_go | dev_acc;
  wire ill_w    = is_cmd & ~acc_w;
  wire burst_go = go & rw_op & (|bank_acc);

  genvar gi;
  generate
    for (gi = 0; gi < NB; gi = gi + 1)
    begin : g_bank
      assign bank_sel[gi] = go & bank_op & bank_range
                          & (cmd.bank == BW'(gi));
      assign bank_bst[gi] = bst_go & (last_bank_reg == BW'(gi));
      assign idle_vec[gi] = (bank_state[gi] == BK_IDLE);
      // register reads wait out bursts and refresh
      assign mrr_blk_vec[gi] = ~(bank_state[gi] inside
        {BK_IDLE, BK_ACTIVE, BK_ACTIVATING, BK_PRECHARGING});

      lbst_bank #(
        .TW    (TW),
        .RP    (RP),
        .RCD   (RCD),
        .BURST (BURST),
        .RFCPB (RFCPB)
      ) u_bank (
        .clk      (clk),
        .srst     (srst),
        .sel      (bank_sel[gi]),
        .op       (cmd.op),
        .ap       (cmd.ap),
        .pre_all  (prea_go),
        .bst      (bank_bst[gi]),
        .st_o     (bank_state[gi]),
        .accept_o (bank_acc[gi]),
        .pre_ok_o (pre_ok_vec[gi])
      );
    end
  endgenerate

  // device-wide timed states; banks keep their own state meanwhile
  always_comb
  begin
    dev_st_next = dev_st_reg;
    dtm_next    = (dtm_reg == '0) ? dtm_reg : dtm_reg - 1'b1;
    case (dev_st_reg)
      DV_NORMAL:
      begin
        if (prea_go)
        begin
          dev_st_next = DV_PRE_ALL;
          dtm_next    = TW'(RP - 1);
        end
        else if (refab_go)
        begin
          dev_st_next = DV_REF_ALL;
          dtm_next    = TW'(RFCAB - 1);
        end
        else if (mrw_go)
        begin
          dev_st_next = DV_MRW;
          dtm_next    = TW'(MRW - 1);
        end
        else if (rst_go)
        begin
          dev_st_next = DV_RESETTING;
          dtm_next    = TW'(INIT - 1);
        end
        else if (mrr_go)
        begin
          // idle banks end idle, open banks end active
          dev_st_next = all_idle_w ? DV_MRR_IDLE : DV_MRR_ACT;
          dtm_next    = TW'(MRR - 1);
        end
      end
      // a register read ends the reset wait early; the rest is dropped
      DV_RESETTING:
      begin
        if (mrr_rst)
        begin
          dev_st_next = DV_MRR_RST;
          dtm_next    = TW'(MRR - 1);
        end
        else if (dtm_reg == '0)
        begin
          dev_st_next = DV_NORMAL;
        end
      end
      DV_REF_ALL, DV_MRR_IDLE, DV_MRR_ACT, DV_MRR_RST,
      DV_MRW, DV_PRE_ALL:
      begin
        if (dtm_reg == '0)
        begin
          dev_st_next = DV_NORMAL;
        end
      end
      // an unused code falls back to normal rather than locking up
      default:
      begin
        dev_st_next = DV_NORMAL;
        dtm_next    = '0;
      end
    endcase
  end

  // cause of a refused command, most basic first
  always_comb
  begin
    err_next = ERR_NONE;
    if (ill_w)
    begin
      if (!cke_ok)
      begin
        err_next = ERR_CKE;
      end
      else if (!dev_free && !dev_rst)
      begin
        err_next = ERR_BUSY;
      end
      else if (bank_op && !bank_range)
      begin
        err_next = ERR_BANK;
      end
      else
      begin
        err_next = ERR_STATE;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cke_prev_reg <= 1'b0;
      xit_reg      <= '0;
    end
    else
    begin
      cke_prev_reg <= cke;
      xit_reg      <= xit_next;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      dev_st_reg <= DV_NORMAL;
      dtm_reg    <= '0;
    end
    else
    begin
      dev_st_reg <= dev_st_next;
      dtm_reg    <= dtm_next;
    end
  end

  // refused reads and writes leave the burst owner where it was
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      last_bank_reg <= '0;
      last_vld_reg  <= 1'b0;
    end
    else if (burst_go)
    begin
      last_bank_reg <= cmd.bank;
      last_vld_reg  <= 1'b1;
    end
  end

  // answers stand for one cycle, from the edge that took the command
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      accept_reg  <= 1'b0;
      illegal_reg <= 1'b0;
      err_reg     <= ERR_NONE;
    end
    else
    begin
      accept_reg  <= acc_w;
      illegal_reg <= ill_w;
      err_reg     <= err_next;
    end
  end

  assign dev_state   = dev_st_reg;
  assign last_bank   = last_bank_reg;
  assign cmd_accept  = accept_reg;
  assign cmd_illegal = illegal_reg;
  assign err_cause   = err_reg;
  // only a register read is taken while the device resets
  assign cmd_ready   = cke_ok & (dev_free | dev_rst);
  assign all_idle    = all_idle_w & dev_free;

endmodule
`default_nettype wire

// ===== sim/lbst_tracker_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module lbst_tracker_asserts
  import lbst_pkg::*;
#(
  parameter int NB    = 8,
  parameter int BW    = 3,
  parameter int RP    = 4,
  parameter int RCD   = 4,
  parameter int BURST = 4,
  parameter int RFCAB = 60,
  parameter int MRR   = 2
)
(
  input wire logic                   clk,
  input wire logic                   srst,
  input wire logic                   cke,
  input wire lbst_cmd_t              cmd,
  input wire lbst_bank_st_t [NB-1:0] bank_state,
  input wire lbst_dev_st_t           dev_state,
  input wire logic [BW-1:0]          last_bank,
  input wire logic                   cmd_accept,
  input wire logic                   cmd_illegal,
  input wire lbst_err_t              err_cause,
  input wire logic                   cmd_ready,
  input wire logic                   all_idle
);
  localparam int APC = BURST + RP;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  wire logic go = cmd.valid && cmd.op != OP_NOP && cmd_ready
                  && dev_state == DV_NORMAL;
  wire logic on2 = cmd.bank == 3'h2;
  wire lbst_bank_st_t s2 = bank_state[2];
  wire logic open2 = s2 inside {BK_ACTIVE, BK_READING, BK_WRITING};
  sequence act2;
    go && on2 && cmd.op == OP_ACT && s2 == BK_IDLE;
  endsequence
  sequence rw2;
    go && on2 && cmd.op inside {OP_RD, OP_WR} && open2;
  endsequence
  sequence pre2;
    go && on2 && cmd.op == OP_PRE && (open2 || s2 == BK_IDLE);
  endsequence
  chk_act_timing: assert property (
    act2 |=> cmd_accept && s2 == BK_ACTIVATING ##RCD s2 == BK_ACTIVE)
    else $error("activate timing wrong");
  chk_pre_timing: assert property (
    pre2 |=> s2 == BK_PRECHARGING ##RP s2 == BK_IDLE)
    else $error("precharge timing wrong");
  chk_rd_enter: assert property (
    rw2 and cmd.op == OP_RD && !cmd.ap |=> cmd_accept
    && s2 == BK_READING && last_bank == 3'h2)
    else $error("read burst not entered");
  chk_wr_enter: assert property (
    rw2 and cmd.op == OP_WR && !cmd.ap |=> cmd_accept
    && s2 == BK_WRITING && last_bank == 3'h2)
    else $error("write burst not entered");
  chk_ap_timing: assert property (
    rw2 and cmd.ap |=> s2 inside {BK_RD_AP, BK_WR_AP} ##APC s2 == BK_IDLE)
    else $error("auto precharge timing wrong");
  chk_bst_stop: assert property (
    go && cmd.op == OP_BST
    && bank_state[last_bank] inside {BK_READING, BK_WRITING}
    |=> cmd_accept && bank_state[$past(last_bank)] == BK_ACTIVE)
    else $error("burst terminate missed");
  chk_mrr_idle: assert property (
    go && cmd.op == OP_MRR && all_idle
    |=> dev_state == DV_MRR_IDLE ##MRR dev_state == DV_NORMAL)
    else $error("register read timing wrong");
  chk_refab_time: assert property (
    go && cmd.op == OP_REFAB && all_idle
    |=> dev_state == DV_REF_ALL ##RFCAB all_idle)
    else $error("all bank refresh timing wrong");
  chk_busy_refuse: assert property (
    cmd.valid && cmd.op != OP_NOP && !cmd_ready
    |=> cmd_illegal && !cmd_accept && err_cause != ERR_NONE)
    else $error("command taken while not ready");
  chk_cke_gate: assert property (
    $rose(cke) |-> !cmd_ready ##1 !cmd_ready)
    else $error("ready too soon after clock enable");
endmodule
bind lbst_tracker lbst_tracker_asserts #(
  .NB(NB), .BW(BW), .RP(RP), .RCD(RCD), .BURST(BURST),
  .RFCAB(RFCAB), .MRR(MRR)
) lbst_tracker_asserts_inst (
  .clk(clk), .srst(srst), .cke(cke), .cmd(cmd),
  .bank_state(bank_state), .dev_state(dev_state),
  .last_bank(last_bank), .cmd_accept(cmd_accept),
  .cmd_illegal(cmd_illegal), .err_cause(err_cause),
  .cmd_ready(cmd_ready), .all_idle(all_idle)
);
`default_nettype wire

// ===== sim/lbst_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module lbst_ctrl_model
  import lbst_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      srst,
  input  wire lbst_cmd_t req,
  input  wire logic      cke_req,
  output lbst_cmd_t      cmd,
  output logic           cke
);
  // launch on the falling edge so the bus is settled at the rising one
  always @(negedge clk)
  begin
    cmd <= srst ? '0 : req;
    cke <= cke_req;
  end
endmodule
`default_nettype wire

// ===== sim/lbst_tracker_test.sv
`timescale 1ns/1ps
`default_nettype none
module lbst_tracker_test
  import lbst_pkg::*;
;
  localparam int RP = 4;
  localparam int RCD = 4;
  localparam int BURST = 4;
  localparam int RFCPB = 30;
  localparam int RFCAB = 60;
  localparam int MRR = 3;
  localparam int MRW = 5;
  logic                clk = 1'b0;
  logic                srst = 1'b1;
  logic                cke_req = 1'b0;
  lbst_cmd_t           req = '0;
  lbst_cmd_t           cmd;
  logic                cke;
  lbst_bank_st_t [7:0] bank_state;
  lbst_dev_st_t        dev_state;
  logic [2:0]          last_bank;
  logic                cmd_accept;
  logic                cmd_illegal;
  lbst_err_t           err_cause;
  logic                cmd_ready;
  logic                all_idle;
  int                  fails = 0;
  int                  n_checks = 0;
  int                  cyc = 0;
  lbst_ctrl_model lbst_ctrl_model_inst (
    .clk(clk), .srst(srst), .req(req), .cke_req(cke_req),
    .cmd(cmd), .cke(cke)
  );
  lbst_tracker #(
    .RP(RP), .RCD(RCD), .BURST(BURST), .RFCPB(RFCPB),
    .RFCAB(RFCAB), .MRR(MRR), .MRW(MRW)
  ) lbst_tracker_inst (
    .clk(clk), .srst(srst), .cke(cke), .cmd(cmd),
    .bank_state(bank_state), .dev_state(dev_state),
    .last_bank(last_bank), .cmd_accept(cmd_accept),
    .cmd_illegal(cmd_illegal), .err_cause(err_cause),
    .cmd_ready(cmd_ready), .all_idle(all_idle)
  );
  initial
    forever #5 clk = ~clk;
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      fails++;
      finish_test();
    end
  end
  task automatic chk(string nm, logic [3:0] seen, logic [3:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // returns just after the edge that took the command
  task automatic go(lbst_op_t op, logic [2:0] b, logic ap);
    wt(1);
    req = '{1'b1, op, b, ap};
    wt(1);
    req = '0;
  endtask
  task automatic ans(logic ok, lbst_err_t e);
    chk("accept", cmd_accept, ok);
    chk("illegal", cmd_illegal, !ok);
    chk("cause", err_cause, e);
  endtask
  // state s must last rem more cycles, then become nx
  task automatic span(bit dv, int rem, logic [3:0] s, logic [3:0] nx);
    wt(rem);
    chk("state", dv ? {1'b0, dev_state} : bank_state[2], s);
    wt(1);
    chk("state", dv ? {1'b0, dev_state} : bank_state[2], nx);
  endtask
  task automatic t_cke();
    wt(1);
    cke_req = 1'b1;
    go(OP_ACT, 3'h2, 1'b0);
    ans(1'b0, ERR_CKE);
    chk("ready", cmd_ready, 4'h0);
    wt(6);
    chk("ready", cmd_ready, 4'h1);
  endtask
  task automatic t_act();
    go(OP_ACT, 3'h2, 1'b0);
    ans(1'b1, ERR_NONE);
    go(OP_ACT, 3'h2, 1'b0);
    ans(1'b0, ERR_STATE);
    span(1'b0, RCD - 3, BK_ACTIVATING, BK_ACTIVE);
  endtask
  task automatic t_rw();
    go(OP_REFAB, 3'h0, 1'b0);
    ans(1'b0, ERR_STATE);
    go(OP_RD, 3'h2, 1'b0);
    ans(1'b1, ERR_NONE);
    chk("bank2", bank_state[2], BK_READING);
    chk("last", {1'b0, last_bank}, 4'h2);
    go(OP_BST, 3'h5, 1'b0);
    chk("bank2", bank_state[2], BK_ACTIVE);
    go(OP_RD, 3'h2, 1'b0);
    go(OP_RD, 3'h2, 1'b0);
    ans(1'b1, ERR_NONE);
    go(OP_BST, 3'h2, 1'b0);
    go(OP_WR, 3'h2, 1'b0);
    span(1'b0, BURST - 1, BK_WRITING, BK_ACTIVE);
    go(OP_RD, 3'h2, 1'b0);
    ans(1'b1, ERR_NONE);
  endtask
  task automatic t_pre();
    repeat (2)
    begin
      go(OP_PRE, 3'h2, 1'b0);
      ans(1'b1, ERR_NONE);
      span(1'b0, RP - 1, BK_PRECHARGING, BK_IDLE);
    end
  endtask
  task automatic t_ap();
    for (int i = 0; i < 2; i++)
    begin
      go(OP_ACT, 3'h2, 1'b0);
      wt(RCD);
      go(i ? OP_WR : OP_RD, 3'h2, 1'b1);
      ans(1'b1, ERR_NONE);
      go(OP_PRE, 3'h2, 1'b0);
      ans(1'b0, ERR_STATE);
      span(1'b0, BURST + RP - 3, i ? BK_WR_AP : BK_RD_AP, BK_IDLE);
    end
  endtask
  task automatic t_bank_misc();
    go(OP_RD, 3'h6, 1'b0);
    ans(1'b0, ERR_STATE);
    go(OP_REFPB, 3'h2, 1'b0);
    span(1'b0, RFCPB - 1, BK_REFRESHING, BK_IDLE);
    go(OP_ACT, 3'h2, 1'b0);
    wt(RCD);
    go(OP_MRR, 3'h0, 1'b0);
    span(1'b1, MRR - 1, DV_MRR_ACT, DV_NORMAL);
    chk("bank2", bank_state[2], BK_ACTIVE);
    go(OP_PRE, 3'h2, 1'b0);
    wt(RP);
  endtask
  task automatic t_dev();
    lbst_op_t     ops [4] = '{OP_REFAB, OP_MRW, OP_MRR, OP_PREA};
    lbst_dev_st_t sts [4] = '{DV_REF_ALL, DV_MRW, DV_MRR_IDLE, DV_PRE_ALL};
    int           len [4] = '{RFCAB, MRW, MRR, RP};
    for (int i = 0; i < 4; i++)
    begin
      go(ops[i], 3'h0, 1'b0);
      ans(1'b1, ERR_NONE);
      go(OP_ACT, 3'h3, 1'b0);
      ans(1'b0, ERR_BUSY);
      span(1'b1, len[i] - 3, sts[i], DV_NORMAL);
      chk("all_idle", all_idle, 4'h1);
    end
  endtask
  task automatic t_rst();
    go(OP_RESET, 3'h0, 1'b0);
    ans(1'b1, ERR_NONE);
    chk("dev", {1'b0, dev_state}, DV_RESETTING);
    go(OP_ACT, 3'h3, 1'b0);
    ans(1'b0, ERR_STATE);
    go(OP_MRR, 3'h0, 1'b0);
    ans(1'b1, ERR_NONE);
    span(1'b1, MRR - 1, DV_MRR_RST, DV_NORMAL);
    chk("all_idle", all_idle, 4'h1);
  endtask
  initial
  begin
    repeat (20) @(negedge clk);
    srst = 1'b0;
    t_cke();
    t_act();
    t_rw();
    t_pre();
    t_ap();
    t_bank_misc();
    t_dev();
    t_rst();
    finish_test();
  end
endmodule
`default_nettype wire
